// ===== cbrp_consts.svh
`ifndef CBRP_CONSTS_SVH
`define CBRP_CONSTS_SVH

// Register bus
`define CBRP_ADDR_W        8
`define CBRP_DATA_W        32
`define CBRP_OFF_COND      8'h00
`define CBRP_OFF_COUNT     8'h04
`define CBRP_OFF_STATUS    8'h08
`define CBRP_OFF_DISP      8'h0c
`define CBRP_COND_RESET    32'h0000_0000
`define CBRP_COUNT_RESET   32'h0000_0000

// Branch options field, option bit 0 is the most significant
`define CBRP_OPT_W         5
`define CBRP_OPT_CR_IGN    4
`define CBRP_OPT_CR_VAL    3
`define CBRP_OPT_CTR_KEEP  2
`define CBRP_OPT_CTR_ZERO  1
`define CBRP_OPT_REVERSE   0

// Instruction fields
`define CBRP_IDX_W         5
`define CBRP_IDX_TOP       5'h1f
`define CBRP_BDISP_W       14
`define CBRP_BDISP_SIGN    13
`define CBRP_DISP_W        16

// Status register bit positions
`define CBRP_ST_STALL      0
`define CBRP_ST_PRED       1
`define CBRP_ST_TAKEN      2
`define CBRP_ST_MISS       3

`endif

// ===== cbrp_pkg.sv
`include "cbrp_consts.svh"

package cbrp_pkg;

  typedef enum logic [1:0] {
    CBRP_FORM_REL   = 2'b00,
    CBRP_FORM_ABS   = 2'b01,
    CBRP_FORM_LINK  = 2'b10,
    CBRP_FORM_COUNT = 2'b11
  } cbrp_form_t;

  typedef enum logic {
    CBRP_ST_IDLE    = 1'b0,
    CBRP_ST_STALLED = 1'b1
  } cbrp_state_t;

  typedef struct packed {
    logic                       valid;
    cbrp_form_t                 form;
    logic [`CBRP_OPT_W-1:0]     branch_options_field;
    logic [`CBRP_IDX_W-1:0]     cond_bit_index;
    logic [`CBRP_BDISP_W-1:0]   cond_displacement_field;
  } cbrp_req_t;

endpackage

// ===== cbrp_resolve.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrp_consts.svh"

// What this block does
// - Option bit 0 clear tests a condition bit
// - Condition test passes when bit equals option 1
// - Option bit 2 clear decrements count, tests result
// - Option bit 3 picks nonzero or zero count
// - Option bit 2 set leaves count untouched
// - Both tests enabled: both must pass
// - Nothing tested: branch always taken
// - Default prediction is always-case OR sign
// - Sign is displacement sign, zero for link/count
// - Absolute forms predict by sign too
// - Option bit 4 inverts default prediction
// - Always-taken encoding never reversed
// - Prefetch predicted path, stall on misprediction
// - Bit index selects one of 32 bits
// - Displacement is field with two zero bits
module cbrp_resolve (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESETN,
  input  wire logic [`CBRP_ADDR_W-1:0]   REG_ADDR,
  input  wire logic [`CBRP_DATA_W-1:0]   REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output var  logic [`CBRP_DATA_W-1:0]   REG_RDATA,
  input  wire cbrp_pkg::cbrp_req_t       DEC_REQ,
  input  wire logic                      FETCH_CORRECT,
  output var  logic                      PRED_VALID,
  output var  logic                      PRED_TAKEN,
  output var  logic                      BR_TAKEN,
  output var  logic                      MISPREDICT,
  output var  logic                      STALL,
  output var  logic [`CBRP_DISP_W-1:0]   TARGET_DISP
);
  import cbrp_pkg::*;

  logic [`CBRP_DATA_W-1:0] condition_register;
  logic [`CBRP_DATA_W-1:0] count_register;
  cbrp_state_t             state;
  logic                    last_miss;

  // Instruction field decode
  wire [`CBRP_OPT_W-1:0] opts      = DEC_REQ.branch_options_field;
  wire                   cr_ignore = opts[`CBRP_OPT_CR_IGN];
  wire                   cr_value  = opts[`CBRP_OPT_CR_VAL];
  wire                   ctr_keep  = opts[`CBRP_OPT_CTR_KEEP];
  wire                   ctr_zero  = opts[`CBRP_OPT_CTR_ZERO];
  wire                   reverse   = opts[`CBRP_OPT_REVERSE];

  // Bit 0 of the condition register is its most significant bit
  wire [`CBRP_IDX_W-1:0] cr_pos = `CBRP_IDX_TOP - DEC_REQ.cond_bit_index;
  wire                   cr_bit = condition_register[cr_pos];

  // Condition register test
  wire cr_ok = cr_ignore | (cr_bit == cr_value);

  // Count register test on the decremented value
  wire [`CBRP_DATA_W-1:0] ctr_dec  = count_register - `CBRP_DATA_W'(1);
  wire                    ctr_is0  = (ctr_dec == '0);
  wire                    ctr_ok   = ctr_keep | (ctr_is0 == ctr_zero);

  // Both enabled tests must pass; none enabled means always
  wire branch_always = cr_ignore & ctr_keep;
  wire next_taken    = cr_ok & ctr_ok;

  // Sign for prediction: link and count targets carry no displacement
  wire disp_form  = (DEC_REQ.form == CBRP_FORM_REL) |
                    (DEC_REQ.form == CBRP_FORM_ABS);
  wire pred_sign  = disp_form & DEC_REQ.cond_displacement_field[`CBRP_BDISP_SIGN];
  wire pred_dflt  = branch_always | pred_sign;

  // Reversal does not apply to the always-taken encoding
  wire next_pred  = branch_always ? 1'b1 : (pred_dflt ^ reverse);

  // Signed displacement with two zero bits appended
  wire [`CBRP_DISP_W-1:0] next_disp = {DEC_REQ.cond_displacement_field, 2'b00};

  // A request is refused while the fetcher refills after a miss
  wire accept     = DEC_REQ.valid & (state == CBRP_ST_IDLE);
  wire next_miss  = next_pred != next_taken;
  wire ctr_update = accept & ~ctr_keep;

  // Register bus decode
  wire sel_cond   = (REG_ADDR == `CBRP_OFF_COND);
  wire sel_count  = (REG_ADDR == `CBRP_OFF_COUNT);
  wire sel_status = (REG_ADDR == `CBRP_OFF_STATUS);
  wire sel_disp   = (REG_ADDR == `CBRP_OFF_DISP);

  wire [`CBRP_DATA_W-1:0] status_word = {
    {(`CBRP_DATA_W - 4){1'b0}},
    last_miss, BR_TAKEN, PRED_TAKEN, STALL
  };

  wire [`CBRP_DATA_W-1:0] next_rdata =
    sel_cond   ? condition_register :
    sel_count  ? count_register :
    sel_status ? status_word :
    sel_disp   ? {{(`CBRP_DATA_W - `CBRP_DISP_W){1'b0}}, TARGET_DISP} :
                 '0;

  // Decrement wins over a software write landing in the same cycle
  wire [`CBRP_DATA_W-1:0] next_count =
    ctr_update           ? ctr_dec :
    (REG_WR & sel_count) ? REG_WDATA :
                           count_register;

  // Pipeline state: a miss holds off decode until the right path arrives
  cbrp_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      CBRP_ST_IDLE: begin
        if (accept && next_miss) begin
          next_state = CBRP_ST_STALLED;
        end
      end
      CBRP_ST_STALLED: begin
        if (FETCH_CORRECT) begin
          next_state = CBRP_ST_IDLE;
        end
      end
      default: begin
        next_state = CBRP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state <= CBRP_ST_IDLE;
      STALL <= 1'b0;
    end else begin
      state <= next_state;
      STALL <= (next_state == CBRP_ST_STALLED);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      condition_register <= `CBRP_COND_RESET;
      count_register     <= `CBRP_COUNT_RESET;
    end else begin
      count_register <= next_count;
      if (REG_WR && sel_cond) begin
        condition_register <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= '0;
    end
  end

  // Prediction and resolution, both one cycle after acceptance
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PRED_VALID  <= 1'b0;
      PRED_TAKEN  <= 1'b0;
      BR_TAKEN    <= 1'b0;
      MISPREDICT  <= 1'b0;
      last_miss   <= 1'b0;
      TARGET_DISP <= '0;
    end else begin
      PRED_VALID <= accept;
      MISPREDICT <= accept & next_miss;
      if (accept) begin
        PRED_TAKEN  <= next_pred;
        BR_TAKEN    <= next_taken;
        last_miss   <= next_miss;
        TARGET_DISP <= next_disp;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  property p_always_taken;
    accept && branch_always |=> BR_TAKEN && PRED_TAKEN;
  endproperty
  a_always_taken: assert property (p_always_taken)
    else $error("Always-taken branch not taken or not predicted taken");

  property p_cr_fail;
    accept && !cr_ignore && (cr_bit != cr_value) |=> PRED_VALID && !BR_TAKEN;
  endproperty
  a_cr_fail: assert property (p_cr_fail)
    else $error("Branch taken although condition bit mismatched");

  property p_cr_ignored;
    accept && cr_ignore && ctr_keep |=> BR_TAKEN;
  endproperty
  a_cr_ignored: assert property (p_cr_ignored)
    else $error("Condition register affected an untested branch");

  property p_ctr_dec;
    ctr_update |=> count_register == $past(count_register) - 32'h1;
  endproperty
  a_ctr_dec: assert property (p_ctr_dec)
    else $error("Count register not decremented by one");

  property p_ctr_keep;
    accept && ctr_keep && !(REG_WR && sel_count) |=> $stable(count_register);
  endproperty
  a_ctr_keep: assert property (p_ctr_keep)
    else $error("Count register changed although kept");

  property p_ctr_sense;
    accept && !ctr_keep && cr_ignore && (ctr_is0 != ctr_zero) |=> !BR_TAKEN;
  endproperty
  a_ctr_sense: assert property (p_ctr_sense)
    else $error("Count test sense not honoured");

  // Expected outcome rebuilt from the decode wires, with the count test taken from the raw count register
  property p_both;
    accept && !ctr_keep && !cr_ignore |=>
      BR_TAKEN == (($past(cr_bit) == $past(cr_value)) &&
                   (($past(count_register) == 32'h1) == $past(ctr_zero)));
  endproperty
  a_both: assert property (p_both)
    else $error("Combined test not the AND of both tests");

  property p_writeback;
    ctr_update && !next_taken |=> count_register == $past(ctr_dec);
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("Decremented count lost on a not-taken branch");

  property p_reverse;
    accept && !branch_always |=>
      PRED_TAKEN == ($past(pred_sign) ^ $past(reverse));
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("Prediction reversal wrong");

  property p_no_sign_lr;
    accept && !disp_form && !branch_always && !reverse |=> !PRED_TAKEN;
  endproperty
  a_no_sign_lr: assert property (p_no_sign_lr)
    else $error("Link or count branch predicted taken by default");

  property p_stall;
    accept && next_miss |=> STALL && MISPREDICT ##1 STALL;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Misprediction did not stall the pipeline");

  property p_stall_refuse;
    STALL && !FETCH_CORRECT |=> !PRED_VALID && STALL;
  endproperty
  a_stall_refuse: assert property (p_stall_refuse)
    else $error("Request accepted or stall dropped while refilling");

  property p_disp;
    accept |=> TARGET_DISP[1:0] == 2'b00 &&
      TARGET_DISP[15:2] == $past(DEC_REQ.cond_displacement_field);
  endproperty
  a_disp: assert property (p_disp)
    else $error("Displacement not built from the field");

  property p_cr_select;
    accept && !cr_ignore && ctr_keep |=>
      BR_TAKEN == ($past(condition_register[`CBRP_IDX_TOP - DEC_REQ.cond_bit_index]) ==
                   $past(cr_value));
  endproperty
  a_cr_select: assert property (p_cr_select)
    else $error("Tested condition bit not the indexed one");

  property p_ctr_only;
    accept && cr_ignore && !ctr_keep |=>
      BR_TAKEN == (($past(count_register) == 32'h1) == $past(ctr_zero));
  endproperty
  a_ctr_only: assert property (p_ctr_only)
    else $error("Counter-only branch decided wrongly");

  property p_sign_pred;
    accept && disp_form && !branch_always && !reverse |=>
      PRED_TAKEN == $past(DEC_REQ.cond_displacement_field[`CBRP_BDISP_SIGN]);
  endproperty
  a_sign_pred: assert property (p_sign_pred)
    else $error("Displacement sign did not set the default prediction");

  property p_no_reverse_always;
    accept && branch_always && reverse |=> PRED_TAKEN;
  endproperty
  a_no_reverse_always: assert property (p_no_reverse_always)
    else $error("Always-taken branch prediction was reversed");

  property p_miss_flag;
    PRED_VALID |-> MISPREDICT == (PRED_TAKEN != BR_TAKEN);
  endproperty
  a_miss_flag: assert property (p_miss_flag)
    else $error("Misprediction flag disagrees with outcome");

  property p_stall_release;
    STALL && FETCH_CORRECT |=> !STALL;
  endproperty
  a_stall_release: assert property (p_stall_release)
    else $error("Stall held after the correct path arrived");

endmodule
`default_nettype wire

// ===== cbrp_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrp_consts.svh"
module testbench;
  import cbrp_pkg::*;
  typedef struct packed {
    logic        pred;
    logic        taken;
    logic        miss;
    logic [15:0] disp;
  } cbrp_exp_t;

  logic        CLK_SYS       = 1'b0;
  logic        RESETN        = 1'b0;
  logic [7:0]  REG_ADDR      = 8'h00;
  logic [31:0] REG_WDATA     = 32'h0;
  logic        REG_WR        = 1'b0;
  logic        REG_RD        = 1'b0;
  logic [31:0] REG_RDATA;
  cbrp_req_t   DEC_REQ       = '0;
  logic        FETCH_CORRECT = 1'b0;
  logic        PRED_VALID;
  logic        PRED_TAKEN;
  logic        BR_TAKEN;
  logic        MISPREDICT;
  logic        STALL;
  logic [15:0] TARGET_DISP;
  cbrp_exp_t   expq[$];
  cbrp_exp_t   got;
  logic [31:0] last_status;
  int          num_errors    = 0;
  int          cmp_count     = 0;
  int          cyc           = 0;

  cbrp_resolve dut_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .DEC_REQ(DEC_REQ), .FETCH_CORRECT(FETCH_CORRECT), .PRED_VALID(PRED_VALID),
    .PRED_TAKEN(PRED_TAKEN), .BR_TAKEN(BR_TAKEN), .MISPREDICT(MISPREDICT),
    .STALL(STALL), .TARGET_DISP(TARGET_DISP));

  always #12.5 CLK_SYS = ~CLK_SYS;

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask

  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK_SYS);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(negedge CLK_SYS);
    check(name, REG_RDATA, exp);
  endtask

  // One branch per option encoding; mispredicts also probe refusal while stalled
  task run(input logic [4:0] o);
    cbrp_req_t   r;
    cbrp_exp_t   e;
    logic [31:0] cnd;
    logic [31:0] cnt;
    logic [31:0] dec;
    logic        s;
    cnd = $urandom;
    cnt = ($urandom % 2) ? ($urandom % 3) : $urandom;
    wr(`CBRP_OFF_COND, cnd);
    wr(`CBRP_OFF_COUNT, cnt);
    r.valid = 1'b1;
    r.form = cbrp_form_t'($urandom % 4);
    r.branch_options_field = o;
    r.cond_bit_index = 5'($urandom);
    r.cond_displacement_field = 14'($urandom);
    dec = cnt - 32'h1;
    e.taken = (o[2] | ((dec == 32'h0) == o[1])) & (o[4] | (cnd[31 - r.cond_bit_index] == o[3]));
    s = r.form[1] ? 1'b0 : r.cond_displacement_field[13];
    e.pred = (o[4] & o[2]) | (s ^ o[0]);
    e.miss = e.pred != e.taken;
    e.disp = {r.cond_displacement_field, 2'b00};
    @(posedge CLK_SYS);
    DEC_REQ <= r;
    expq.push_back(e);
    @(posedge CLK_SYS);
    if (e.miss) begin
      @(negedge CLK_SYS);
      check("stall_set", STALL, 1);
      @(posedge CLK_SYS);
      FETCH_CORRECT <= 1'b1;
    end
    DEC_REQ.valid <= 1'b0;
    if (e.miss) begin
      @(posedge CLK_SYS);
      FETCH_CORRECT <= 1'b0;
      @(negedge CLK_SYS);
      check("stall_clr", STALL, 0);
    end
    rd("count", `CBRP_OFF_COUNT, o[2] ? cnt : dec);
    last_status = {28'h0, e.miss, e.taken, e.pred, 1'b0};
    rd("status", `CBRP_OFF_STATUS, last_status);
    rd("disp", `CBRP_OFF_DISP, {16'h0, e.disp});
  endtask

  // Results are matched in issue order; a refused request must leave no result
  always @(negedge CLK_SYS) begin
    if (PRED_VALID === 1'b1) begin
      if (expq.size() == 0) begin
        check("extra_result", 1, 0);
      end else begin
        got = expq.pop_front();
        check("pred", PRED_TAKEN, got.pred);
        check("taken", BR_TAKEN, got.taken);
        check("miss", MISPREDICT, got.miss);
        check("tdisp", TARGET_DISP, got.disp);
      end
    end
  end

  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 12000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    void'($urandom(32'hd5b1));
    repeat (6) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd("cond_rst", `CBRP_OFF_COND, `CBRP_COND_RESET);
    rd("count_rst", `CBRP_OFF_COUNT, `CBRP_COUNT_RESET);
    // Three passes so every encoding meets several counts and forms
    for (int i = 0; i < 96; i++) begin
      run(5'(i));
    end
    wr(`CBRP_OFF_STATUS, 32'hffff_ffff);
    rd("status_ro", `CBRP_OFF_STATUS, last_status);
    rd("unmapped", 8'h10, 32'h0);
    check("queue_left", expq.size(), 0);
    final_report;
  end
endmodule
`default_nettype wire
